// ===== hw/fawd_pkg.sv
package fawd_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [7:0]  REG_CLEAR_CODE      = 8'h06;
    localparam logic [7:0]  REG_SOFT_RESET      = 8'h07;
    localparam logic [7:0]  REG_SPECIAL_CONFIG  = 8'h0b;
    localparam logic [7:0]  REG_ALARM_ACTION    = 8'h10;
    localparam logic [7:0]  REG_WATCHDOG_CONFIG = 8'h11;
    localparam logic [7:0]  REG_FAULT_MASK      = 8'h1d;

    localparam logic [15:0] CLEAR_CODE_RESET      = 16'h0000;
    localparam logic [15:0] SPECIAL_CONFIG_RESET  = 16'h0000;
    localparam logic [15:0] ALARM_ACTION_RESET    = 16'h8020;
    localparam logic [15:0] WATCHDOG_CONFIG_RESET = 16'h0018;
    localparam logic [15:0] FAULT_MASK_RESET      = 16'hefdf;
    localparam logic [7:0]  SOFT_RESET_KEY        = 8'had;

    localparam int SC_RELOAD_BIT = 2;
    localparam int SC_LEVEL_BIT  = 1;
    localparam int SC_AUX_BIT    = 0;
    localparam logic [15:0] SPECIAL_CONFIG_WMASK  = 16'h0007;
    localparam logic [15:0] WATCHDOG_CONFIG_WMASK = 16'h003f;

    localparam int WD_UP_LSB = 3;
    localparam int WD_LO_LSB = 1;
    localparam int WD_EN_BIT = 0;

    // Fault sources, index i uses alarm_action bits [2i+1:2i].
    localparam int NUM_FAULTS       = 8;
    localparam int FLT_OVERHEAT_WRN = 0;
    localparam int FLT_OVERHEAT_ERR = 1;
    localparam int FLT_REFERENCE    = 2;
    localparam int FLT_LINK_CHECK   = 3;
    localparam int FLT_FIRST_INPUT  = 4;
    localparam int FLT_SECOND_INPUT = 5;
    localparam int FLT_DIE_HEAT     = 6;
    localparam int FLT_SELF_DIAG    = 7;

    // Mask bit position for each fault source, in source order.
    localparam int MASK_POS [NUM_FAULTS] = '{0, 1, 5, 7, 3, 4, 2, 13};
    localparam int MASK_WD_BIT = 6;

    typedef enum logic [1:0] {
        FAWD_ACT_NONE,
        FAWD_ACT_CLEAR,
        FAWD_ACT_ALARM,
        FAWD_ACT_HIZ
    } fawd_action_e;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CORE_CLK_HZ   = 100_000_000;
    localparam int WD_TICK_HZ    = 1200;
    localparam int OSC_HZ        = 1_228_800;
    localparam int OSC_DIV       = 1024;
    localparam int TICK_CYCLES   = CORE_CLK_HZ / (OSC_HZ / OSC_DIV);
    localparam int TICK_CNT_W    = 17;
    localparam int WD_CNT_W      = 13;

    localparam logic [15:0] VOLTAGE_OUTPUT_ALARM_LOW  = 16'h0000;
    localparam logic [15:0] VOLTAGE_OUTPUT_ALARM_HIGH = 16'hffff;

endpackage : fawd_pkg

// ===== hw/fawd_wd_if.sv
`timescale 1ns/100ps
interface fawd_wd_if;
    import fawd_pkg::*;
    logic       tick;
    logic       enable;
    logic [2:0] upper_code;
    logic [1:0] lower_code;
    logic       any_write;
    logic       wd_write;
    logic       error;
    logic [WD_CNT_W-1:0] count;

    modport ctrl (output tick, enable, upper_code, lower_code, any_write, wd_write,
                  input error, count);
    modport timer (input tick, enable, upper_code, lower_code, any_write, wd_write,
                   output error, count);
endinterface : fawd_wd_if

// ===== hw/fawd_watchdog.sv
`timescale 1ns/100ps
module fawd_watchdog
    import fawd_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst,
    fawd_wd_if.timer    wd
);

    logic [WD_CNT_W-1:0] count_q;
    logic                error_q;
    logic [WD_CNT_W-1:0] upper_ticks;
    logic [WD_CNT_W-1:0] lower_ticks;
    logic                restart;
    logic                early;

    always_comb begin
        case (wd.upper_code)
            3'h0:    upper_ticks = 13'd64;
            3'h1:    upper_ticks = 13'd128;
            3'h2:    upper_ticks = 13'd512;
            3'h3:    upper_ticks = 13'd1024;
            3'h4:    upper_ticks = 13'd2048;
            3'h5:    upper_ticks = 13'd3072;
            3'h6:    upper_ticks = 13'd4096;
            default: upper_ticks = 13'd6144;
        endcase
        case (wd.lower_code)
            2'h1:    lower_ticks = 13'd64;
            2'h2:    lower_ticks = 13'd128;
            2'h3:    lower_ticks = 13'd512;
            default: lower_ticks = 13'd0;
        endcase
    end

    // With a window only the watchdog register restarts; otherwise any write.
    assign restart = (wd.lower_code != 2'h0) ? wd.wd_write : wd.any_write;
    assign early   = (wd.lower_code != 2'h0) && wd.wd_write
                     && (count_q < lower_ticks);

    always_ff @(posedge core_clk) begin
        if (rst || !wd.enable) begin
            count_q <= '0;
        end else if (restart) begin
            count_q <= '0;
        end else if (wd.tick && count_q <= upper_ticks) begin
            count_q <= count_q + 13'd1;
        end
    end

    // The error is sticky until a valid restart or the watchdog is disabled.
    always_ff @(posedge core_clk) begin
        if (rst || !wd.enable) begin
            error_q <= 1'b0;
        end else if (early || (count_q > upper_ticks)) begin
            error_q <= 1'b1;
        end else if (restart) begin
            error_q <= 1'b0;
        end
    end

    assign wd.error = error_q;
    assign wd.count = count_q;

endmodule : fawd_watchdog

// ===== hw/fawd_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Soft reset also reloads factory trim only when the reload bit is set.
// - Effective alarm level is level bit OR pin, pin only when aux disabled.
// - Reset or alarm action drives output low or high per effective level.
// - Aux enable low: pin is polarity, converter samples ground; high: input.
// - Action codes: none, clear, alarm level, high impedance.
// - Self-diagnostic action in bits 15..14, resets to alarm level.
// - Bits 13..12 act on die temperature threshold fault, reset none.
// - Bits 11..10 act on second input threshold fault, reset none.
// - Bits 9..8 act on first input threshold fault, reset none.
// - Bits 7..6 act on frame check or watchdog error, reset none.
// - Bits 5..4 act on reference fault, reset to alarm level.
// - Bits 3..2 act on overheat error above 130 C, reset none.
// - Bits 1..0 act on overheat warning above 85 C, reset none.
// - Watchdog counts 1200 Hz ticks from oscillator divided by 1024.
// - Upper limit codes select 64 to 6144 ticks, reset code 3.
// - Enabled watchdog errors when count passes upper limit unrestarted.
// - Lower limit codes select off, 64, 128 or 512 ticks, reset off.
// - With lower limit on, only watchdog register writes restart the timer.
// - With lower limit on, early or late watchdog writes raise an error.
// - Watchdog register bit 0 enables the watchdog, default off.
// - Status flags always follow faults; masks block the alarm action.
// - Clear action drives the converter with the clear code register.
// - Writing ADh to the soft reset field starts a software reset.
module fawd_top
    import fawd_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  hw_reset_active,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    output logic      [15:0]           reg_rdata,
    input  wire logic                  polarity_or_aux_pin,
    input  wire logic [NUM_FAULTS-1:0] fault_in,
    input  wire logic [15:0]           dac_code_in,
    output logic      [NUM_FAULTS-1:0] fault_status,
    output logic                       watchdog_error,
    output logic                       soft_reset_pulse,
    output logic                       trim_reload_pulse,
    output logic                       aux_channel_active,
    output logic                       effective_alarm_level,
    output logic      [15:0]           voltage_output_code,
    output logic                       voltage_output_hiz
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] special_config_q;
    logic [15:0] alarm_action_q;
    logic [15:0] watchdog_config_q;
    logic [15:0] clear_code_q;
    logic [15:0] fault_mask_q;
    logic        soft_reset_q;
    logic        trim_reload_q;

    always_ff @(posedge core_clk) begin
        if (rst || soft_reset_q) begin
            special_config_q  <= SPECIAL_CONFIG_RESET;
            alarm_action_q    <= ALARM_ACTION_RESET;
            watchdog_config_q <= WATCHDOG_CONFIG_RESET;
            clear_code_q      <= CLEAR_CODE_RESET;
            fault_mask_q      <= FAULT_MASK_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_SPECIAL_CONFIG:  special_config_q  <= reg_wdata & SPECIAL_CONFIG_WMASK;
                REG_ALARM_ACTION:    alarm_action_q    <= reg_wdata;
                REG_WATCHDOG_CONFIG: watchdog_config_q <= reg_wdata & WATCHDOG_CONFIG_WMASK;
                REG_CLEAR_CODE:      clear_code_q      <= reg_wdata;
                REG_FAULT_MASK:      fault_mask_q      <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Software reset
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            soft_reset_q  <= 1'b0;
            trim_reload_q <= 1'b0;
        end else begin
            soft_reset_q  <= reg_wr && reg_addr == REG_SOFT_RESET
                             && reg_wdata[7:0] == SOFT_RESET_KEY;
            trim_reload_q <= reg_wr && reg_addr == REG_SOFT_RESET
                             && reg_wdata[7:0] == SOFT_RESET_KEY
                             && special_config_q[SC_RELOAD_BIT];
        end
    end

    assign soft_reset_pulse  = soft_reset_q;
    assign trim_reload_pulse = trim_reload_q;

    always_comb begin
        case (reg_addr)
            REG_SPECIAL_CONFIG:  reg_rdata = special_config_q;
            REG_ALARM_ACTION:    reg_rdata = alarm_action_q;
            REG_WATCHDOG_CONFIG: reg_rdata = watchdog_config_q;
            REG_CLEAR_CODE:      reg_rdata = clear_code_q;
            REG_FAULT_MASK:      reg_rdata = fault_mask_q;
            default:             reg_rdata = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Polarity pin synchroniser and alarm level
    // ****************************************************************
    logic [2:0] pin_sync_q;
    logic       pin_level_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_sync_q <= 3'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], polarity_or_aux_pin};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_level_q <= 1'b0;
        end else if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_level_q <= pin_sync_q[2];
        end
    end

    logic alarm_level;
    assign alarm_level = special_config_q[SC_LEVEL_BIT]
                         | (pin_level_q & ~special_config_q[SC_AUX_BIT]);
    assign aux_channel_active = special_config_q[SC_AUX_BIT];

    // ****************************************************************
    // Watchdog tick divider and timer
    // ****************************************************************
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic                  tick_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    fawd_wd_if wd_bus ();

    assign wd_bus.tick       = tick_q;
    assign wd_bus.enable     = watchdog_config_q[WD_EN_BIT];
    assign wd_bus.upper_code = watchdog_config_q[WD_UP_LSB +: 3];
    assign wd_bus.lower_code = watchdog_config_q[WD_LO_LSB +: 2];
    assign wd_bus.any_write  = reg_wr;
    assign wd_bus.wd_write   = reg_wr && reg_addr == REG_WATCHDOG_CONFIG;

    fawd_watchdog u_watchdog (
        .core_clk (core_clk),
        .rst      (rst),
        .wd       (wd_bus.timer)
    );

    assign watchdog_error = wd_bus.error;

    // ****************************************************************
    // Fault action selection
    // ****************************************************************
    logic [NUM_FAULTS-1:0] fault_now;
    logic [NUM_FAULTS-1:0] fault_armed;
    logic [1:0]            act_code [NUM_FAULTS];

    always_comb begin
        fault_now = fault_in;
        fault_now[FLT_LINK_CHECK] = fault_in[FLT_LINK_CHECK] | wd_bus.error;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_fault
            // Link source: frame fault is blocked by its own mask bit, watchdog error by the watchdog mask bit.
            if (gi == FLT_LINK_CHECK) begin : g_link
                assign fault_armed[gi] =
                    (fault_in[gi] & ~fault_mask_q[MASK_POS[gi]])
                    | (wd_bus.error & ~fault_mask_q[MASK_WD_BIT]);
            end else begin : g_plain
                assign fault_armed[gi] = fault_now[gi] & ~fault_mask_q[MASK_POS[gi]];
            end
            // Bits 2i+1:2i: placement.
            assign act_code[gi] = alarm_action_q[2*gi +: 2];
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_status <= '0;
        end else begin
            fault_status <= fault_now;
        end
    end

    fawd_action_e action;
    always_comb begin
        action = FAWD_ACT_NONE;
        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (fault_armed[i] && act_code[i] > action) begin
                action = fawd_action_e'(act_code[i]);
            end
        end
    end

    // ****************************************************************
    // Output state
    // ****************************************************************
    logic [15:0] voltage_output_q;
    logic        hiz_q;
    logic        level_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            voltage_output_q  <= VOLTAGE_OUTPUT_ALARM_LOW;
            hiz_q   <= 1'b0;
            level_q <= 1'b0;
        end else begin
            level_q <= alarm_level;
            hiz_q   <= 1'b0;
            if (hw_reset_active) begin
                voltage_output_q <= alarm_level ? VOLTAGE_OUTPUT_ALARM_HIGH : VOLTAGE_OUTPUT_ALARM_LOW;
            end else begin
                case (action)
                    FAWD_ACT_CLEAR: voltage_output_q <= clear_code_q;
                    FAWD_ACT_ALARM: voltage_output_q <= alarm_level ? VOLTAGE_OUTPUT_ALARM_HIGH
                                                          : VOLTAGE_OUTPUT_ALARM_LOW;
                    FAWD_ACT_HIZ: begin
                        voltage_output_q <= dac_code_in;
                        hiz_q  <= 1'b1;
                    end
                    default: voltage_output_q <= dac_code_in;
                endcase
            end
        end
    end

    assign voltage_output_code   = voltage_output_q;
    assign voltage_output_hiz    = hiz_q;
    assign effective_alarm_level = level_q;

endmodule : fawd_top

// ===== verification/fawd_host_model.sv
`timescale 1ns/100ps
module fawd_host_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] reg_rdata,
    output logic             reg_wr,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata
);
    // ****************************************************************
    // Register access of the host
    // ****************************************************************
    initial {reg_wr, reg_addr, reg_wdata} = 25'h0;

    // Idle cycles before the strobe let the host service promptly or slowly.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int idle);
        repeat (idle) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : fawd_host_model

// ===== verification/fawd_top_sva.sv
`timescale 1ns/100ps
module fawd_top_sva
    import fawd_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  hw_reset_active,
    input wire logic                  reg_wr,
    input wire logic [7:0]            reg_addr,
    input wire logic [15:0]           reg_wdata,
    input wire logic [15:0]           reg_rdata,
    input wire logic [NUM_FAULTS-1:0] fault_in,
    input wire logic [NUM_FAULTS-1:0] fault_status,
    input wire logic                  watchdog_error,
    input wire logic                  soft_reset_pulse,
    input wire logic                  trim_reload_pulse,
    input wire logic                  aux_channel_active,
    input wire logic                  effective_alarm_level,
    input wire logic [15:0]           voltage_output_code
);
    // ****************************************************************
    // Shadow of the configuration and time since the last watchdog write
    // ****************************************************************
    logic        lvl_q, trim_q, en_q;
    logic [1:0]  lo_q;
    logic [23:0] cyc_q;
    wire logic   key_wr = reg_wr && reg_addr == REG_SOFT_RESET && reg_wdata[7:0] == 8'had;

    always_ff @(posedge core_clk) begin
        if (rst || soft_reset_pulse) begin
            {trim_q, lvl_q, lo_q, en_q} <= 5'h0;
        end else if (reg_wr && reg_addr == REG_SPECIAL_CONFIG) begin
            {trim_q, lvl_q} <= reg_wdata[2:1];
        end else if (reg_wr && reg_addr == REG_WATCHDOG_CONFIG) begin
            {lo_q, en_q} <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || soft_reset_pulse || (reg_wr && reg_addr == REG_WATCHDOG_CONFIG) || !en_q) begin
            cyc_q <= 24'h0;
        end else if (cyc_q != 24'hffffff) begin
            cyc_q <= cyc_q + 24'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_key_wr; key_wr; endsequence
    sequence s_wd_wr; reg_wr && reg_addr == REG_WATCHDOG_CONFIG; endsequence
    sequence s_hw_held; hw_reset_active [*3]; endsequence

    property p_key_pulse; s_key_wr |=> soft_reset_pulse; endproperty
    a_key_pulse: assert property (p_key_pulse) else $error("no soft reset pulse");
    property p_no_pulse; !key_wr |=> !soft_reset_pulse; endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("stray soft reset");
    property p_trim; soft_reset_pulse |-> trim_reload_pulse == trim_q; endproperty
    a_trim: assert property (p_trim) else $error("trim reload wrong");
    property p_aux;
        reg_wr && reg_addr == REG_SPECIAL_CONFIG |=> aux_channel_active == $past(reg_wdata[0]);
    endproperty
    a_aux: assert property (p_aux) else $error("aux enable wrong");
    property p_level; lvl_q && $past(lvl_q) |-> effective_alarm_level; endproperty
    a_level: assert property (p_level) else $error("alarm level low");
    property p_hw;
        s_hw_held |-> voltage_output_code == (effective_alarm_level ? 16'hffff : 16'h0000);
    endproperty
    a_hw: assert property (p_hw) else $error("reset output wrong");
    property p_status; (fault_status & 8'hf7) == ($past(fault_in) & 8'hf7); endproperty
    a_status: assert property (p_status) else $error("status wrong");
    property p_wd_rd;
        s_wd_wr ##1 reg_addr == REG_WATCHDOG_CONFIG |-> reg_rdata == ($past(reg_wdata) & 16'h003f);
    endproperty
    a_wd_rd: assert property (p_wd_rd) else $error("watchdog read wrong");
    property p_wd_off; !en_q [*3] |-> !watchdog_error; endproperty
    a_wd_off: assert property (p_wd_off) else $error("error while off");
    property p_early;
        s_wd_wr ##0 (reg_wdata[0] && en_q && lo_q != 2'h0 && cyc_q < 24'd64) |-> ##[1:2] watchdog_error;
    endproperty
    a_early: assert property (p_early) else $error("early write missed");
endmodule : fawd_top_sva

bind fawd_top fawd_top_sva u_sva (
    .core_clk, .rst, .hw_reset_active, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .fault_in,
    .fault_status, .watchdog_error, .soft_reset_pulse, .trim_reload_pulse, .aux_channel_active,
    .effective_alarm_level, .voltage_output_code
);

// ===== verification/fawd_top_tb.sv
`timescale 1ns/100ps
module fawd_top_tb
    import fawd_pkg::*;
;
    logic                  core_clk = 1'b0;
    logic                  rst, hw_reset_active, polarity_or_aux_pin, reg_wr, watchdog_error;
    logic                  soft_reset_pulse, trim_reload_pulse, aux_channel_active;
    logic                  effective_alarm_level, voltage_output_hiz;
    logic [NUM_FAULTS-1:0] fault_in, fault_status;
    logic [7:0]            reg_addr;
    logic [15:0]           dac_code_in, reg_wdata, reg_rdata, voltage_output_code;
    wire logic [16:0]      out = {voltage_output_hiz, voltage_output_code};
    int                    num_errors = 0;
    int                    n_checks = 0;
    int                    cycles = 0;

    fawd_top DUT (
        .core_clk, .rst, .hw_reset_active, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .polarity_or_aux_pin, .fault_in, .dac_code_in, .fault_status, .watchdog_error,
        .soft_reset_pulse, .trim_reload_pulse, .aux_channel_active, .effective_alarm_level,
        .voltage_output_code, .voltage_output_hiz
    );
    fawd_host_model host (.core_clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);

    always #5 core_clk = ~core_clk;

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] r;
        host.rd(a, r);
        chk({1'b0, r}, {1'b0, e});
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // The highest action code among active faults decides the output.
    function automatic logic [16:0] exp_out(input logic [15:0] act, clr, dac,
                                            input logic [7:0] f, input logic lvl);
        logic [1:0] m;
        m = 2'h0;
        for (int i = 0; i < NUM_FAULTS; i++) if (f[i] && act[2*i+:2] > m) m = act[2*i+:2];
        case (m)
            2'h1: return {1'b0, clr};
            2'h2: return {1'b0, lvl ? 16'hffff : 16'h0000};
            2'h3: return {1'b1, dac};
            default: return {1'b0, dac};
        endcase
    endfunction : exp_out

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [15:0] a, c, d;
        logic [7:0]  f;
        logic        l;
        {rst, hw_reset_active, polarity_or_aux_pin, fault_in, dac_code_in} = 27'h4000000;
        void'($urandom(32'hd3a0));
        cyc(3);
        rst = 1'b0;
        rdchk(REG_SPECIAL_CONFIG, 16'h0000);
        rdchk(REG_ALARM_ACTION, 16'h8020);
        rdchk(REG_WATCHDOG_CONFIG, 16'h0018);
        host.wr(8'h55, 16'hffff, 0);
        rdchk(8'h55, 16'h0000);
        host.wr(REG_WATCHDOG_CONFIG, 16'hfffe, 1);
        rdchk(REG_WATCHDOG_CONFIG, 16'h003e);
        host.wr(REG_SPECIAL_CONFIG, 16'hffff, 0);
        rdchk(REG_SPECIAL_CONFIG, 16'h0007);
        host.wr(REG_ALARM_ACTION, 16'h1234, 0);
        host.wr(REG_SOFT_RESET, 16'h00ad, 0);
        chk({15'h0, soft_reset_pulse, trim_reload_pulse}, 17'h3);
        rdchk(REG_ALARM_ACTION, 16'h8020);
        rdchk(REG_WATCHDOG_CONFIG, 16'h0018);
        host.wr(REG_SOFT_RESET, 16'h00ad, 0);
        chk({15'h0, soft_reset_pulse, trim_reload_pulse}, 17'h2);
        host.wr(REG_SOFT_RESET, 16'h00ac, 0);
        chk({15'h0, soft_reset_pulse, trim_reload_pulse}, 17'h0);
        for (int i = 0; i < 8; i++) begin
            host.wr(REG_SPECIAL_CONFIG, {14'h0, i[1:0]}, 0);
            polarity_or_aux_pin = i[2];
            cyc(6);
            chk({15'h0, aux_channel_active, effective_alarm_level},
                {15'h0, i[0], i[1] | (i[2] & ~i[0])});
        end
        for (int i = 0; i < 2; i++) begin
            host.wr(REG_SPECIAL_CONFIG, {14'h0, i[0], 1'b1}, 0);
            cyc(3);
            hw_reset_active = 1'b1;
            cyc(4);
            chk(out, {1'b0, {16{i[0]}}});
            hw_reset_active = 1'b0;
        end
        host.wr(REG_FAULT_MASK, 16'h0000, 0);
        for (int k = 0; k < 24; k++) begin
            a = 16'($urandom);
            c = 16'($urandom);
            d = 16'($urandom);
            f = 8'($urandom);
            l = 1'($urandom);
            if (k < 4) begin
                a = {8{k[1:0]}};
                f = 8'hff;
            end
            host.wr(REG_ALARM_ACTION, a, 0);
            host.wr(REG_CLEAR_CODE, c, 0);
            host.wr(REG_SPECIAL_CONFIG, {14'h0, l, 1'b1}, 0);
            dac_code_in = d;
            fault_in = f;
            cyc(4);
            chk(out, exp_out(a, c, d, f, l));
            chk({9'h0, fault_status}, {9'h0, f});
            fault_in = 8'h00;
            cyc(4);
            chk(out, {1'b0, d});
        end
        host.wr(REG_FAULT_MASK, 16'hefdf, 0);
        host.wr(REG_ALARM_ACTION, 16'h8000, 0);
        fault_in = 8'h80;
        cyc(4);
        chk(out, {1'b0, dac_code_in});
        chk({16'h0, fault_status[7]}, 17'h1);
        fault_in = 8'h00;
        host.wr(REG_WATCHDOG_CONFIG, 16'h001b, 0);
        host.wr(REG_WATCHDOG_CONFIG, 16'h001b, 2);
        cyc(2);
        chk({16'h0, watchdog_error}, 17'h1);
        host.wr(REG_FAULT_MASK, 16'hef9f, 0);
        host.wr(REG_ALARM_ACTION, 16'h0040, 0);
        cyc(2);
        chk(out, {1'b0, c});
        host.wr(REG_WATCHDOG_CONFIG, 16'h0000, 0);
        cyc(3);
        chk({16'h0, watchdog_error}, 17'h0);
        host.wr(REG_WATCHDOG_CONFIG, 16'h0001, 0);
        cyc(1500);
        host.wr(REG_CLEAR_CODE, 16'h0000, 3);
        cyc(1500);
        chk({16'h0, watchdog_error}, 17'h0);
        summarize();
    end
endmodule : fawd_top_tb
